//--- xor_chain_pin_test.sv
// Board pin connectivity test built from two XOR chains
`timescale 1ns/1ps

// How it works
// R1: Two independent XOR chains, each driving its own output pin.
// R2: First chain runs from IDE data bit 8 to overcurrent 0, out on gp pin 8.
// R3: Second chain runs from power event to LAN reset/sync, out on battery-low.
// R4: RTC well reset low for 7 PCI clocks with power good enters test mode.
// R5: Corrected order: bit 15 before bit 2, 13 before write strobe, no audio in 0.
// R6: Each output is the running XOR of all inputs in its chain.

module xor_chain_pin_test
	import xor_chain_pkg::*;
#(
	parameter int PCI_DIV = xor_chain_pkg::PCI_DIV_CYCLES
) (
	input  wire logic                              sys_clk,
	input  wire logic                              reset,
	input  wire logic                              power_good,
	input  wire logic                              rtc_well_reset_n,
	input  wire xor_chain_pkg::chain_one_pins_type chain_one_pins,
	input  wire xor_chain_pkg::chain_two_pins_type chain_two_pins,
	output xor_chain_pkg::pin_drive_type           gp_pin_eight,
	output xor_chain_pkg::pin_drive_type           battery_low_n,
	output logic                                   test_mode
);

	import xor_chain_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	chain_one_pins_type        one_s;
	chain_two_pins_type        two_s;
	logic [1:0]                ctrl_s;
	logic                      power_good_s;
	logic                      rtc_reset_low_s;
	logic [PCI_DIV_WIDTH-1:0]  pci_div_reg;
	logic                      pci_tick;
	logic [ENTRY_WIDTH-1:0]    entry_count_reg;
	entry_state_type           state_reg;
	logic [CHAIN_ONE_LEN-1:0]  one_bits;
	logic [CHAIN_TWO_LEN-1:0]  two_bits;
	logic [CHAIN_ONE_LEN-1:0]  one_run;
	logic [CHAIN_TWO_LEN-1:0]  two_run;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	pin_sync #(.WIDTH($bits(chain_one_pins_type))) one_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in (chain_one_pins),
		.sync_out (one_s)
	);

	pin_sync #(.WIDTH($bits(chain_two_pins_type))) two_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in (chain_two_pins),
		.sync_out (two_s)
	);

	pin_sync #(.WIDTH(2)) ctrl_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in ({power_good, rtc_well_reset_n}),
		.sync_out (ctrl_s)
	);

	assign power_good_s    = ctrl_s[1];
	assign rtc_reset_low_s = ~ctrl_s[0];

	// ****************************************
	// PCI clock rate enable
	// ****************************************
	// Entry is timed in PCI clocks, so a divider stands in for that clock
	always_ff @(posedge sys_clk) begin
		if (reset || pci_tick) begin
			pci_div_reg <= '0;
		end else begin
			pci_div_reg <= pci_div_reg + 4'h1;
		end
	end

	assign pci_tick = (pci_div_reg == PCI_DIV_WIDTH'(PCI_DIV - 1));

	// ****************************************
	// Entry sequence
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (reset || state_reg != COUNTING) begin
			entry_count_reg <= '0;
		end else if (pci_tick) begin
			entry_count_reg <= entry_count_reg + 3'h1; // R4
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_reg <= IDLE;
		end else begin
			case (state_reg)
				IDLE: begin
					if (power_good_s && rtc_reset_low_s) begin
						state_reg <= COUNTING; // R4
					end
				end
				COUNTING: begin
					if (!power_good_s || !rtc_reset_low_s) begin
						state_reg <= IDLE; // R4
					end else if (pci_tick &&
					             entry_count_reg == ENTRY_PCI_CLOCKS - 3'h1) begin
						state_reg <= TESTING; // R4
					end
				end
				TESTING: begin
					// Loss of power good is the only way out short of reset
					if (!power_good_s) begin
						state_reg <= IDLE;
					end
				end
				default: begin
					state_reg <= IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// First chain, in link order
	// ****************************************
	assign one_bits = { // R2 R5
		one_s.overcurrent_zero_n,
		one_s.gp_pin_38_43[4],
		one_s.gp_pin_38_43[5],
		one_s.gp_pin_38_43[2],
		one_s.gp_pin_38_43[1],
		one_s.gp_pin_38_43[3],
		one_s.speaker,
		one_s.gp_pin_38_43[0],
		one_s.serial_irq,
		one_s.fpu_error_n,
		one_s.apic_data[1],
		one_s.apic_data[0],
		one_s.hub_comp,
		one_s.hub_data[0],
		one_s.hub_data[2],
		one_s.hub_data[1],
		one_s.hub_data[8],
		one_s.hub_data[3],
		one_s.hub_data[10],
		one_s.hub_strobe,
		one_s.hub_data[4],
		one_s.hub_data[9],
		one_s.hub_data[5],
		one_s.hub_data[6],
		one_s.hub_data[11],
		one_s.hub_data[7],
		one_s.sec_ide_sel1_n,
		one_s.sec_ide_sel3_n,
		one_s.sec_ide_addr[0],
		one_s.sec_ide_addr[2],
		one_s.sec_ide_addr[1],
		one_s.sec_ide_dma_ack_n,
		one_s.sec_ide_read_strobe_n,
		one_s.sec_ide_ready,
		one_s.sec_ide_data[1],
		one_s.sec_ide_write_strobe_n,
		one_s.sec_ide_data[14],
		one_s.sec_ide_dma_req,
		one_s.sec_ide_data[0],
		one_s.sec_ide_data[2],
		one_s.sec_ide_data[13],
		one_s.sec_ide_data[4],
		one_s.sec_ide_data[15],
		one_s.sec_ide_data[12],
		one_s.sec_ide_data[9],
		one_s.sec_ide_data[3],
		one_s.sec_ide_data[11],
		one_s.sec_ide_data[10],
		one_s.sec_ide_data[7],
		one_s.sec_ide_data[5],
		one_s.sec_ide_data[6],
		one_s.sec_ide_data[8]
	};

	// ****************************************
	// Second chain, in link order
	// ****************************************
	// Audio serial input 0 has no place here; its pin is left untested
	assign two_bits = { // R3 R5
		two_s.lan_reset_sync,
		two_s.eeprom_data_out,
		two_s.eeprom_data_in,
		two_s.lan_rx_data[0],
		two_s.lan_rx_data[1],
		two_s.eeprom_select,
		two_s.lan_tx_data[0],
		two_s.lan_rx_data[2],
		two_s.eeprom_clock,
		two_s.lan_tx_data[1],
		two_s.lan_tx_data[2],
		two_s.usb_neg[5],
		two_s.usb_pos[5],
		two_s.usb_neg[4],
		two_s.usb_pos[4],
		two_s.usb_neg[3],
		two_s.usb_pos[3],
		two_s.usb_neg[2],
		two_s.usb_pos[2],
		two_s.usb_neg[1],
		two_s.usb_pos[1],
		two_s.usb_neg[0],
		two_s.usb_pos[0],
		two_s.audio_reset_n,
		two_s.overcurrent_n[5],
		two_s.overcurrent_n[1],
		two_s.overcurrent_n[2],
		two_s.overcurrent_n[3],
		two_s.overcurrent_n[4],
		two_s.smb_alert_n,
		two_s.smb_data,
		two_s.sleep_s3_n,
		two_s.smb_clock,
		two_s.suspend_status_n,
		two_s.suspend_clock,
		two_s.sm_link[0],
		two_s.clock_run_n,
		two_s.power_button_n,
		two_s.sm_link[1],
		two_s.gp_pin_27,
		two_s.sleep_s5_n,
		two_s.gp_pin_12,
		two_s.gp_pin_28,
		two_s.gp_pin_13,
		two_s.pci_reset_n,
		two_s.gp_pin_25,
		two_s.power_mgmt_event_n
	};

	// ****************************************
	// Running XOR along each chain
	// ****************************************
	assign one_run[0] = one_bits[0];
	assign two_run[0] = two_bits[0];

	generate
		for (genvar i = 1; i < CHAIN_ONE_LEN; i++) begin : g_one
			assign one_run[i] = one_run[i-1] ^ one_bits[i]; // R6
		end
		for (genvar j = 1; j < CHAIN_TWO_LEN; j++) begin : g_two
			assign two_run[j] = two_run[j-1] ^ two_bits[j]; // R6
		end
	endgenerate

	// ****************************************
	// Output pins
	// ****************************************
	// Pins are released outside test mode so normal drivers own them
	always_ff @(posedge sys_clk) begin
		if (reset || state_reg != TESTING) begin
			gp_pin_eight  <= '{value: OUT_RESET, enable: 1'h0};
			battery_low_n <= '{value: OUT_RESET, enable: 1'h0};
		end else begin
			gp_pin_eight  <= '{value: one_run[CHAIN_ONE_LEN-1], enable: 1'h1}; // R1 R2
			battery_low_n <= '{value: two_run[CHAIN_TWO_LEN-1], enable: 1'h1}; // R1 R3
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			test_mode <= 1'h0;
		end else begin
			test_mode <= (state_reg == TESTING); // R4
		end
	end

endmodule

//--- xor_chain_pkg.sv
// Shared constants and pin carriers for the XOR chain pin test block
package xor_chain_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int SYS_CLK_PERIOD_NS = 10;
	localparam int PCI_CLK_PERIOD_NS = 30;
	localparam int PCI_DIV_CYCLES    = (PCI_CLK_PERIOD_NS + SYS_CLK_PERIOD_NS - 1)
	                                   / SYS_CLK_PERIOD_NS;
	localparam int PCI_DIV_WIDTH     = 4;
	localparam int ENTRY_WIDTH       = 3;
	localparam logic [ENTRY_WIDTH-1:0] ENTRY_PCI_CLOCKS = 3'h7;

	// ****************************************
	// Chain sizes and reset values
	// ****************************************
	localparam int CHAIN_ONE_LEN = 52;
	localparam int CHAIN_TWO_LEN = 47;
	localparam logic OUT_RESET   = 1'h0;

	// ****************************************
	// Carriers
	// ****************************************
	typedef enum logic [1:0] {
		IDLE     = 2'h0,
		COUNTING = 2'h1,
		TESTING  = 2'h3
	} entry_state_type;

	typedef struct packed {
		logic value;
		logic enable;
	} pin_drive_type;

	typedef struct packed {
		logic [15:0] sec_ide_data;
		logic        sec_ide_dma_req;
		logic        sec_ide_write_strobe_n;
		logic        sec_ide_ready;
		logic        sec_ide_read_strobe_n;
		logic        sec_ide_dma_ack_n;
		logic [2:0]  sec_ide_addr;
		logic        sec_ide_sel3_n;
		logic        sec_ide_sel1_n;
		logic [11:0] hub_data;
		logic        hub_strobe;
		logic        hub_comp;
		logic [1:0]  apic_data;
		logic        fpu_error_n;
		logic        serial_irq;
		logic [5:0]  gp_pin_38_43;
		logic        speaker;
		logic        overcurrent_zero_n;
	} chain_one_pins_type;

	typedef struct packed {
		logic        power_mgmt_event_n;
		logic        pci_reset_n;
		logic        gp_pin_12;
		logic        gp_pin_13;
		logic        gp_pin_25;
		logic        gp_pin_27;
		logic        gp_pin_28;
		logic        sleep_s3_n;
		logic        sleep_s5_n;
		logic [1:0]  sm_link;
		logic        power_button_n;
		logic        clock_run_n;
		logic        suspend_clock;
		logic        suspend_status_n;
		logic        smb_clock;
		logic        smb_data;
		logic        smb_alert_n;
		logic [5:1]  overcurrent_n;
		logic        audio_reset_n;
		logic [5:0]  usb_pos;
		logic [5:0]  usb_neg;
		logic [2:0]  lan_tx_data;
		logic [2:0]  lan_rx_data;
		logic        eeprom_clock;
		logic        eeprom_select;
		logic        eeprom_data_in;
		logic        eeprom_data_out;
		logic        lan_reset_sync;
	} chain_two_pins_type;

endpackage

//--- pin_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

//--- xor_chain_pin_test_props.sv
// Checker for the XOR chain pin test ports
`timescale 1ns/1ps

module xor_chain_pin_test_props
	import xor_chain_pkg::*;
#(
	parameter int PCI_DIV = xor_chain_pkg::PCI_DIV_CYCLES
) (
	input wire logic                              sys_clk,
	input wire logic                              reset,
	input wire logic                              power_good,
	input wire logic                              rtc_well_reset_n,
	input wire xor_chain_pkg::chain_one_pins_type chain_one_pins,
	input wire xor_chain_pkg::chain_two_pins_type chain_two_pins,
	input wire xor_chain_pkg::pin_drive_type      gp_pin_eight,
	input wire xor_chain_pkg::pin_drive_type      battery_low_n,
	input wire logic                              test_mode
);
	// ****
	// Held entry length
	// ****
	// Delayed like the pin synchroniser so the count lines up with the design
	logic [1:0] held_pipe_reg;
	logic [7:0] held_cnt_reg;
	always_ff @(posedge sys_clk) begin
		held_pipe_reg <= {held_pipe_reg[0], power_good & ~rtc_well_reset_n};
	end
	always_ff @(posedge sys_clk) begin
		if (reset || !held_pipe_reg[1]) begin
			held_cnt_reg <= 8'h00;
		end else if (held_cnt_reg != 8'hff) begin
			held_cnt_reg <= held_cnt_reg + 8'h01;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	chk_one_value: assert property (test_mode |->
		gp_pin_eight.value == ^$past(chain_one_pins, 3)) else $error("chain one wrong");
	chk_two_value: assert property (test_mode |->
		battery_low_n.value == ^$past(chain_two_pins, 3)) else $error("chain two wrong");
	chk_drive_enable: assert property (
		gp_pin_eight.enable == test_mode && battery_low_n.enable == test_mode)
		else $error("pin enable wrong");
	chk_idle_quiet: assert property (!test_mode |->
		!gp_pin_eight.value && !battery_low_n.value) else $error("output not quiet");
	chk_entry_min: assert property ($rose(test_mode) |->
		held_cnt_reg >= 6 * PCI_DIV + 2) else $error("entry too early");
	chk_entry_max: assert property (held_cnt_reg >= 7 * PCI_DIV + 5 |-> test_mode)
		else $error("entry missing");
	chk_exit_power: assert property ($fell(power_good) |-> ##[1:6] !test_mode)
		else $error("no exit on power loss");
	chk_mode_holds: assert property (power_good [*4] ##0 test_mode |=> test_mode)
		else $error("test mode dropped");
	cov_entry: cover property ($rose(test_mode));
	cov_exit: cover property ($fell(test_mode) && !power_good);
	cov_toggle: cover property (test_mode && $changed(battery_low_n.value));
endmodule

//--- board_tester.sv
// Board tester model driving the entry sequence and the chain pins
`timescale 1ns/1ps

module board_tester
	import xor_chain_pkg::*;
(
	input  wire logic                         sys_clk,
	output logic                              power_good,
	output logic                              rtc_well_reset_n,
	output xor_chain_pkg::chain_one_pins_type chain_one_pins,
	output xor_chain_pkg::chain_two_pins_type chain_two_pins
);
	initial begin
		power_good = 1'h0;
		rtc_well_reset_n = 1'h1;
		chain_one_pins = '0;
		chain_two_pins = '0;
	end
	// Power good rises with or before the rtc reset
	task automatic hold_entry(input logic good, input logic rtc_n);
		@(negedge sys_clk);
		power_good = good;
		rtc_well_reset_n = rtc_n;
	endtask
	task automatic set_pins(input chain_one_pins_type one, input chain_two_pins_type two);
		@(negedge sys_clk);
		chain_one_pins = one;
		chain_two_pins = two;
	endtask
endmodule

//--- xor_chain_pin_test_tb_top.sv
// Self-checking bench for the XOR chain pin test block
`timescale 1ns/1ps

module xor_chain_pin_test_tb_top;
	import xor_chain_pkg::*;

	localparam int PCI_DIV = 2;
	logic               sys_clk;
	logic               reset;
	logic               power_good;
	logic               rtc_well_reset_n;
	chain_one_pins_type chain_one_pins;
	chain_two_pins_type chain_two_pins;
	pin_drive_type      gp_pin_eight;
	pin_drive_type      battery_low_n;
	logic               test_mode;
	chain_one_pins_type one;
	chain_two_pins_type two;
	int                 errors;
	int                 num_checks;
	int                 waited;

	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	board_tester u_board_tester (.sys_clk(sys_clk), .power_good(power_good),
		.rtc_well_reset_n(rtc_well_reset_n), .chain_one_pins(chain_one_pins),
		.chain_two_pins(chain_two_pins));

	// Small divider keeps the entry count short
	xor_chain_pin_test #(.PCI_DIV(PCI_DIV)) u_xor_chain_pin_test (.sys_clk(sys_clk),
		.reset(reset), .power_good(power_good), .rtc_well_reset_n(rtc_well_reset_n),
		.chain_one_pins(chain_one_pins), .chain_two_pins(chain_two_pins),
		.gp_pin_eight(gp_pin_eight), .battery_low_n(battery_low_n), .test_mode(test_mode));

	function automatic logic parity(input logic [63:0] bits);
		logic p;
		p = 1'h0;
		for (int i = 0; i < 64; i++) begin
			p = p ^ bits[i];
		end
		return p;
	endfunction

	task automatic check(input logic [1:0] seen, input logic [1:0] expected);
		num_checks++;
		if (seen !== expected) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask

	task automatic apply(input logic mode);
		u_board_tester.set_pins(one, two);
		repeat (3) @(negedge sys_clk);
		check(gp_pin_eight, {mode & parity({12'h000, one}), mode});
		check(battery_low_n, {mode & parity({17'h0_0000, two}), mode});
		check({1'h0, test_mode}, {1'h0, mode});
	endtask

	task automatic enter_mode();
		u_board_tester.hold_entry(1'h1, 1'h0);
		waited = 0;
		while (test_mode !== 1'h1 && waited < 60) begin
			@(negedge sys_clk);
			waited++;
		end
		check({1'h0, waited >= 6 * PCI_DIV + 2 && waited <= 7 * PCI_DIV + 6}, 2'h1);
		repeat (4) @(negedge sys_clk);
		u_board_tester.hold_entry(1'h1, 1'h1);
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		end_of_test();
	end

	initial begin
		errors = 0;
		num_checks = 0;
		reset = 1'h1;
		one = '0;
		two = '0;
		void'($urandom(32'ha8a8_5376));
		repeat (8) @(negedge sys_clk);
		reset = 1'h0;
		one = 52'({$urandom(), $urandom()});
		two = 47'({$urandom(), $urandom()});
		apply(1'h0);
		// Released two ticks short: must stay idle
		u_board_tester.hold_entry(1'h1, 1'h0);
		repeat (5 * PCI_DIV) @(negedge sys_clk);
		u_board_tester.hold_entry(1'h1, 1'h1);
		repeat (30) @(negedge sys_clk);
		check({1'h0, test_mode}, 2'h0);
		enter_mode();
		for (int i = 0; i < 52; i++) begin
			one[i] = ~one[i];
			apply(1'h1);
		end
		for (int i = 0; i < 47; i++) begin
			two[i] = ~two[i];
			apply(1'h1);
		end
		repeat (16) begin
			one = 52'({$urandom(), $urandom()});
			two = 47'({$urandom(), $urandom()});
			apply(1'h1);
		end
		u_board_tester.hold_entry(1'h0, 1'h1);
		repeat (6) @(negedge sys_clk);
		apply(1'h0);
		enter_mode();
		reset = 1'h1;
		repeat (3) @(negedge sys_clk);
		reset = 1'h0;
		apply(1'h0);
		end_of_test();
	end
endmodule

bind xor_chain_pin_test xor_chain_pin_test_props #(.PCI_DIV(PCI_DIV)) u_xor_chain_pin_test_props (
	.sys_clk(sys_clk), .reset(reset), .power_good(power_good),
	.rtc_well_reset_n(rtc_well_reset_n), .chain_one_pins(chain_one_pins),
	.chain_two_pins(chain_two_pins), .gp_pin_eight(gp_pin_eight),
	.battery_low_n(battery_low_n), .test_mode(test_mode));
